// ---- pkg/dsg_consts.svh ----
/*
 constants for the dual spindle gear sequencer: register offsets, field positions,
 reset values and timing counts. assumes a 125 MHz control clock.
*/
`ifndef DSG_CONSTS_SVH
`define DSG_CONSTS_SVH

`define DSG_CLK_MHZ 125
`define DSG_TICK_US 1000
`define DSG_TICK_CYCLES (`DSG_CLK_MHZ * `DSG_TICK_US)
`define DSG_DEFAULT_MS 16'h1388

`define DSG_ADDR_CTRL 8'h00
`define DSG_ADDR_STATUS 8'h04
`define DSG_ADDR_ALARM 8'h08
`define DSG_ADDR_SPEED 8'h0c
`define DSG_ADDR_BRAKE 8'h10
`define DSG_ADDR_SHIFT1 8'h14
`define DSG_ADDR_SHIFT2 8'h18
`define DSG_ADDR_CHECK 8'h1c
`define DSG_ADDR_MAX12 8'h20
`define DSG_ADDR_MAX34 8'h24
`define DSG_ADDR_RELEASE 8'h28

`define DSG_CTRL_MULTI 0
`define DSG_CTRL_HOLD 1
`define DSG_CTRL_AUTO 7
`define DSG_CTRL_MODE_LO 8
`define DSG_CTRL_MODE_HI 9

`define DSG_ALM_REVERSE 0
`define DSG_ALM_WRONG 1
`define DSG_ALM_TIMEOUT 2
`define DSG_ALM_DISABLED 3

`endif

// ---- pkg/dsg_pkg.sv ----
/*
 types of the dual spindle gear sequencer.
 assumes the constants header is included by the users.
*/
package dsg_pkg;
    typedef enum logic [1:0] {DSG_MECH, DSG_ANALOG, DSG_SERIAL, DSG_RSVD} dsg_mode_type;
    typedef enum logic [2:0] {SH_IDLE, SH_FIRST, SH_WAIT, SH_SECOND} dsg_shift_type;
    typedef enum logic [1:0] {SP_STOP, SP_CW, SP_CCW} dsg_dir_type;
endpackage : dsg_pkg

// ---- rtl/dsg_timer.sv ----
/*
 millisecond down counter for the programmable delays.
 assumes tick is a one-cycle pulse from the same clock.
*/
`timescale 1ns/1ns
module dsg_timer
    import dsg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic load,
    input wire logic [15:0] loadValue,
    output logic done
);
    typedef struct packed {
        logic [15:0] count;
        logic done;
    } dsg_timer_state_type;
    dsg_timer_state_type state_reg, state_next;

    // load restarts, each tick counts one millisecond down
    always_comb begin
        state_next = state_reg;
        if (load) begin
            state_next.count = loadValue;
            state_next.done = 1'b0;
        end else if (tick && state_reg.count != 16'h0000) begin
            state_next.count = state_reg.count - 16'h0001;
        end
        if (!load) begin
            state_next.done = (state_next.count == 16'h0000);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign done = state_reg.done;
endmodule : dsg_timer

// ---- rtl/dsg_sequencer.sv ----
/*
 dual spindle selection and four-step range shift sequencer with an
 AXI4-Lite register slave. command pulses come from same-clock logic;
 only the in-position inputs are pins; they pass two flops.
*/
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
`include "dsg_consts.svh"
module dsg_sequencer
    import dsg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic firstCwCmd,
    input wire logic firstCcwCmd,
    input wire logic firstStopCmd,
    input wire logic secondCwCmd,
    input wire logic secondCcwCmd,
    input wire logic secondStopCmd,
    input wire logic range1Cmd,
    input wire logic range2Cmd,
    input wire logic range3Cmd,
    input wire logic range4Cmd,
    input wire logic speedCmd,
    input wire logic [15:0] speedValue,
    input wire logic emergencyStop,
    input wire logic spindleAlarm,
    input wire logic range1InPosition,
    input wire logic range2InPosition,
    input wire logic range3InPosition,
    input wire logic range4InPosition,
    output logic firstCwOut,
    output logic firstCcwOut,
    output logic secondCwOut,
    output logic secondCcwOut,
    output logic brakeOut,
    output logic spindleStopOut,
    output logic serialCwFlag,
    output logic serialCcwFlag,
    output logic lampCw,
    output logic lampCcw,
    output logic lampStop,
    output logic [3:0] rangeSelect,
    output logic [11:0] firstAnalog,
    output logic [11:0] secondAnalog
);
    typedef struct packed {
        logic awDone;
        logic wDone;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic bValid;
        logic rValid;
        logic [31:0] rData;
        logic [31:0] ctrl;
        logic [3:0] alarm;
        logic [11:0] shiftSpeed;
        logic [15:0] brakeDelay;
        logic [15:0] brakeHold;
        logic [15:0] firstTime;
        logic [15:0] secondTime;
        logic [15:0] checkTime;
        logic [15:0] releaseTime;
        logic [15:0] max1;
        logic [15:0] max2;
        logic [15:0] max3;
        logic [15:0] max4;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [16:0] tickCount;
        logic tick;
        logic activeSecond;
        dsg_dir_type dir1;
        dsg_dir_type dir2;
        logic brakePend;
        logic brakeOn;
        dsg_shift_type shift;
        logic [1:0] curRange;
        logic [1:0] newRange;
        logic [3:0] sel;
        logic rangeKnown;
        logic [15:0] speed1;
        logic [15:0] speed2;
        logic [11:0] out1;
        logic [11:0] out2;
    } dsg_state_type;
    dsg_state_type state_reg, state_next;

    logic tmrLoad;
    logic [15:0] tmrValue;
    logic tmrDone;
    logic [3:0] posRaw;

    assign posRaw = {range4InPosition, range3InPosition, range2InPosition, range1InPosition};

    // scales a commanded speed to the 12-bit output by the range maximum
    function automatic logic [11:0] scale(input logic [15:0] spd, input logic [15:0] maxSpd);
        logic [27:0] prod;
        logic [27:0] quo;
        prod = {12'h000, spd} * 28'h0000fff;
        quo = (maxSpd == 16'h0000) ? 28'h0000000 : prod / {12'h000, maxSpd};
        scale = (quo > 28'h0000fff) ? 12'hfff : quo[11:0];
    endfunction : scale

    // picks the maximum speed of a range
    function automatic logic [15:0] rangeMax(input dsg_state_type s, input logic [1:0] r);
        case (r)
            2'h0: rangeMax = s.max1;
            2'h1: rangeMax = s.max2;
            2'h2: rangeMax = s.max3;
            default: rangeMax = s.max4;
        endcase
    endfunction : rangeMax

    // one shared delay timer for brake and shift steps
    dsg_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .tick(state_reg.tick),
        .load(tmrLoad),
        .loadValue(tmrValue),
        .done(tmrDone)
    );

    always_comb begin
        logic multiOk;
        logic analogMode;
        logic rangeReq;
        logic [1:0] reqRange;
        logic [3:0] alarmSet;
        logic wrFire;
        multiOk = 1'b0;
        analogMode = 1'b0;
        rangeReq = 1'b0;
        reqRange = 2'h0;
        alarmSet = 4'h0;
        wrFire = 1'b0;
        state_next = state_reg;
        tmrLoad = 1'b0;
        tmrValue = 16'h0000;

        // pin inputs pass two flops
        state_next.sync1 = posRaw;
        state_next.sync2 = state_reg.sync1;

        // fixed millisecond time base
        state_next.tick = 1'b0;
        if (state_reg.tickCount == 17'(`DSG_TICK_CYCLES - 1)) begin
            state_next.tickCount = 17'h00000;
            state_next.tick = 1'b1;
        end else begin
            state_next.tickCount = state_reg.tickCount + 17'h00001;
        end

        analogMode = (state_reg.ctrl[`DSG_CTRL_MODE_HI:`DSG_CTRL_MODE_LO] == 2'(DSG_ANALOG));
        multiOk = state_reg.ctrl[`DSG_CTRL_MULTI] && analogMode;

        // axi write channel: address and data in either order
        if (s_axi_awvalid && !state_reg.awDone) begin
            state_next.awDone = 1'b1;
            state_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.wDone) begin
            state_next.wDone = 1'b1;
            state_next.wData = s_axi_wdata;
        end
        wrFire = state_reg.awDone && state_reg.wDone && !state_reg.bValid;
        if (wrFire) begin
            state_next.bValid = 1'b1;
            state_next.awDone = 1'b0;
            state_next.wDone = 1'b0;
            case (state_reg.awAddr)
                `DSG_ADDR_CTRL: state_next.ctrl = state_reg.wData;
                `DSG_ADDR_SPEED: state_next.shiftSpeed = state_reg.wData[11:0];
                `DSG_ADDR_BRAKE: begin
                    state_next.brakeDelay = state_reg.wData[15:0];
                    state_next.brakeHold = state_reg.wData[31:16];
                end
                `DSG_ADDR_SHIFT1: state_next.firstTime = state_reg.wData[15:0];
                `DSG_ADDR_SHIFT2: state_next.secondTime = state_reg.wData[15:0];
                `DSG_ADDR_CHECK: state_next.checkTime = state_reg.wData[15:0];
                `DSG_ADDR_MAX12: begin
                    state_next.max1 = state_reg.wData[15:0];
                    state_next.max2 = state_reg.wData[31:16];
                end
                `DSG_ADDR_MAX34: begin
                    state_next.max3 = state_reg.wData[15:0];
                    state_next.max4 = state_reg.wData[31:16];
                end
                `DSG_ADDR_RELEASE: state_next.releaseTime = state_reg.wData[15:0];
                default: ;
            endcase
        end
        if (state_reg.bValid && s_axi_bready) begin
            state_next.bValid = 1'b0;
        end

        // axi read channel
        if (s_axi_arvalid && !state_reg.rValid) begin
            state_next.rValid = 1'b1;
            case (s_axi_araddr)
                `DSG_ADDR_CTRL: state_next.rData = state_reg.ctrl;
                `DSG_ADDR_STATUS: state_next.rData = {16'h0000, state_reg.sel,
                    1'b0, state_reg.shift, state_reg.curRange, state_reg.brakeOn,
                    state_reg.activeSecond, state_reg.dir2, state_reg.dir1};
                `DSG_ADDR_ALARM: state_next.rData = {28'h0000000, state_reg.alarm};
                `DSG_ADDR_SPEED: state_next.rData = {20'h00000, state_reg.shiftSpeed};
                `DSG_ADDR_BRAKE: state_next.rData = {state_reg.brakeHold, state_reg.brakeDelay};
                `DSG_ADDR_SHIFT1: state_next.rData = {16'h0000, state_reg.firstTime};
                `DSG_ADDR_SHIFT2: state_next.rData = {16'h0000, state_reg.secondTime};
                `DSG_ADDR_CHECK: state_next.rData = {16'h0000, state_reg.checkTime};
                `DSG_ADDR_MAX12: state_next.rData = {state_reg.max2, state_reg.max1};
                `DSG_ADDR_MAX34: state_next.rData = {state_reg.max4, state_reg.max3};
                `DSG_ADDR_RELEASE: state_next.rData = {16'h0000, state_reg.releaseTime};
                default: state_next.rData = 32'h00000000;
            endcase
        end
        if (state_reg.rValid && s_axi_rready) begin
            state_next.rValid = 1'b0;
        end

        // first spindle commands; switching back checks direction
        if (firstCwCmd || firstCcwCmd) begin
            if (state_reg.activeSecond && state_reg.dir1 != SP_STOP
                && state_reg.dir1 != (firstCwCmd ? SP_CW : SP_CCW)) begin
                alarmSet[`DSG_ALM_WRONG] = 1'b1;
            end else begin
                state_next.activeSecond = 1'b0;
                state_next.dir1 = firstCwCmd ? SP_CW : SP_CCW;
            end
        end
        if (firstStopCmd) begin
            state_next.dir1 = SP_STOP;
        end

        // second spindle run commands, gated by multi-spindle enable in analog mode
        if ((secondCwCmd || secondCcwCmd) && multiOk) begin
            if (state_reg.dir2 != SP_STOP && state_reg.dir2 != (secondCwCmd ? SP_CW : SP_CCW)) begin
                if (state_reg.activeSecond) begin
                    alarmSet[`DSG_ALM_REVERSE] = 1'b1;
                end else begin
                    alarmSet[`DSG_ALM_WRONG] = 1'b1;
                end
            end else begin
                state_next.activeSecond = 1'b1;
                state_next.dir2 = secondCwCmd ? SP_CW : SP_CCW;
            end
        end
        if (secondStopCmd) begin
            state_next.dir2 = SP_STOP;
        end

        // speed command scales only the addressed spindle
        if (speedCmd) begin
            if (state_next.activeSecond) begin
                state_next.speed2 = speedValue;
                state_next.out2 = scale(speedValue, rangeMax(state_reg, state_reg.curRange));
            end else begin
                state_next.speed1 = speedValue;
                state_next.out1 = scale(speedValue, rangeMax(state_reg, state_reg.curRange));
            end
        end

        // emergency or drive alarm stops both at once
        if (emergencyStop || spindleAlarm) begin
            state_next.dir1 = SP_STOP;
            state_next.dir2 = SP_STOP;
        end

        // brake on second spindle after stop, then hold
        if (state_reg.dir2 != SP_STOP && state_next.dir2 == SP_STOP) begin
            state_next.brakePend = 1'b1;
            state_next.brakeOn = 1'b0;
            tmrLoad = state_reg.shift == SH_IDLE;
            tmrValue = state_reg.brakeDelay;
        end else if (state_reg.shift == SH_IDLE && tmrDone && state_reg.brakePend) begin
            state_next.brakePend = 1'b0;
            state_next.brakeOn = 1'b1;
            tmrLoad = 1'b1;
            tmrValue = state_reg.brakeHold;
        end else if (state_reg.shift == SH_IDLE && tmrDone && state_reg.brakeOn) begin
            state_next.brakeOn = 1'b0;
        end

        // range commands
        rangeReq = range1Cmd || range2Cmd || range3Cmd || range4Cmd;
        reqRange = range1Cmd ? 2'h0 : range2Cmd ? 2'h1 : range3Cmd ? 2'h2 : 2'h3;

        // four-step range shift
        case (state_reg.shift)
            SH_IDLE: begin
                if (rangeReq) begin
                    if (!state_reg.ctrl[`DSG_CTRL_AUTO] || !analogMode) begin
                        alarmSet[`DSG_ALM_DISABLED] = 1'b1;
                    end else if (reqRange != state_reg.curRange || !state_reg.rangeKnown) begin
                        state_next.newRange = reqRange;
                        state_next.out1 = state_reg.shiftSpeed;
                        state_next.shift = SH_FIRST;
                        tmrLoad = 1'b1;
                        tmrValue = state_reg.firstTime;
                    end
                end
            end
            SH_FIRST: begin
                if (tmrDone) begin
                    state_next.sel = 4'h1 << state_reg.newRange;
                    state_next.curRange = state_reg.newRange;
                    state_next.rangeKnown = 1'b1;
                    state_next.shift = SH_WAIT;
                    tmrLoad = 1'b1;
                    tmrValue = state_reg.checkTime;
                end
            end
            SH_WAIT: begin
                if (state_reg.sync2[state_reg.newRange]) begin
                    state_next.shift = SH_SECOND;
                    tmrLoad = 1'b1;
                    tmrValue = state_reg.secondTime;
                end else if (tmrDone) begin
                    alarmSet[`DSG_ALM_TIMEOUT] = 1'b1;
                    state_next.shift = SH_IDLE;
                end
            end
            SH_SECOND: begin
                if (tmrDone) begin
                    state_next.out1 = scale(state_reg.speed1, rangeMax(state_reg, state_reg.curRange));
                    if (!state_reg.ctrl[`DSG_CTRL_HOLD]) begin
                        state_next.sel = 4'h0;
                    end
                    state_next.shift = SH_IDLE;
                end
            end
            default: state_next.shift = SH_IDLE;
        endcase

        // alarms are sticky; write ones to clear, a new event wins
        if (wrFire && state_reg.awAddr == `DSG_ADDR_ALARM) begin
            state_next.alarm = state_reg.alarm & ~state_reg.wData[3:0];
        end
        state_next.alarm = state_next.alarm | alarmSet;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.releaseTime <= `DSG_DEFAULT_MS;
            state_reg.secondTime <= `DSG_DEFAULT_MS;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs come straight from the state flops
    always_comb begin
        logic serial;
        serial = (state_reg.ctrl[`DSG_CTRL_MODE_HI:`DSG_CTRL_MODE_LO] == 2'(DSG_SERIAL));
        firstCwOut = !serial && state_reg.dir1 == SP_CW;
        firstCcwOut = !serial && state_reg.dir1 == SP_CCW;
        serialCwFlag = serial && state_reg.dir1 == SP_CW;
        serialCcwFlag = serial && state_reg.dir1 == SP_CCW;
    end
    assign secondCwOut = state_reg.dir2 == SP_CW;
    assign secondCcwOut = state_reg.dir2 == SP_CCW;
    assign brakeOut = state_reg.brakeOn;
    assign spindleStopOut = state_reg.dir1 == SP_STOP && state_reg.dir2 == SP_STOP;
    assign lampCw = state_reg.dir1 == SP_CW;
    assign lampCcw = state_reg.dir1 == SP_CCW;
    assign lampStop = state_reg.dir1 == SP_STOP;
    assign rangeSelect = state_reg.sel;
    assign firstAnalog = state_reg.out1;
    assign secondAnalog = state_reg.out2;
    assign s_axi_awready = !state_reg.awDone;
    assign s_axi_wready = !state_reg.wDone;
    assign s_axi_bvalid = state_reg.bValid;
    assign s_axi_bresp = 2'h0;
    assign s_axi_arready = !state_reg.rValid;
    assign s_axi_rvalid = state_reg.rValid;
    assign s_axi_rdata = state_reg.rData;
    assign s_axi_rresp = 2'h0;
endmodule : dsg_sequencer

// ---- sim/dsg_sequencer_asserts.sv ----
/* checker on the sequencer ports: spindle outputs, lamps and range selects.
   assumes it is bound to the sequencer and shares its clock and reset. */
`timescale 1ns/1ns
module dsg_sequencer_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic emergencyStop,
    input wire logic spindleAlarm,
    input wire logic firstCwCmd,
    input wire logic firstCcwCmd,
    input wire logic firstStopCmd,
    input wire logic secondCwCmd,
    input wire logic secondCcwCmd,
    input wire logic secondStopCmd,
    input wire logic firstCwOut,
    input wire logic firstCcwOut,
    input wire logic secondCwOut,
    input wire logic secondCcwOut,
    input wire logic spindleStopOut,
    input wire logic serialCwFlag,
    input wire logic lampCw,
    input wire logic [3:0] rangeSelect
);
    // all checks on the control clock, idle in reset
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_range_onehot: assert property ($onehot0(rangeSelect))
        else $error("more than one range select active");
    a_halt_clears: assert property (emergencyStop || spindleAlarm |=>
        !firstCwOut && !firstCcwOut && !secondCwOut && !secondCcwOut && spindleStopOut)
        else $error("halt left a spindle running");
    a_first_stop: assert property (firstStopCmd && !firstCwCmd && !firstCcwCmd |=>
        !firstCwOut && !firstCcwOut)
        else $error("first spindle still turning after stop");
    a_second_stop: assert property (secondStopCmd && !secondCwCmd && !secondCcwCmd |=>
        !secondCwOut && !secondCcwOut)
        else $error("second spindle still turning after stop");
    a_no_reverse: assert property (secondCwOut && secondCcwCmd |=> !secondCcwOut)
        else $error("second spindle reversed directly");
    a_second_cause: assert property ($rose(secondCwOut) |-> $past(secondCwCmd))
        else $error("second spindle started without its command");
    a_first_cause: assert property ($rose(firstCwOut) |->
        $past(firstCwCmd) || $past(serialCwFlag))
        else $error("first spindle started without its command");
    a_lamp_first: assert property (secondCwCmd && !firstCwCmd && !firstCcwCmd
        && !firstStopCmd && !emergencyStop && !spindleAlarm |=> $stable(lampCw))
        else $error("lamp followed the second spindle");
    a_serial_excl: assert property (serialCwFlag |-> !firstCwOut && !firstCcwOut)
        else $error("discrete outputs driven in serial mode");
    // main scenarios reached
    c_second_runs: cover property ($rose(secondCwOut));
    c_range_two: cover property (rangeSelect == 4'h2);
    c_serial_flag: cover property ($rose(serialCwFlag));
endmodule : dsg_sequencer_asserts

bind dsg_sequencer dsg_sequencer_asserts u_asserts (.*);

// ---- sim/dsg_gearbox_model.sv ----
/* gearbox model: travels to the selected range, then closes its position switch.
   assumes a one-hot or zero range select; stall jams the gearbox. */
`timescale 1ns/1ns
module dsg_gearbox_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] rangeSelect,
    input wire logic stall,
    output logic [3:0] inPosition
);
    logic [3:0] posReg;
    logic [7:0] cntReg;
    logic moving;
    // no switch is closed while the gears travel
    assign moving = (rangeSelect != 4'h0) && (rangeSelect != posReg);
    assign inPosition = moving ? 4'h0 : posReg;
    // travel timer, held at zero while jammed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            posReg <= 4'h0;
            cntReg <= 8'h0;
        end else if (!moving || stall) begin
            cntReg <= 8'h0;
        end else if (cntReg == 8'h13) begin
            posReg <= rangeSelect;
            cntReg <= 8'h0;
        end else begin
            cntReg <= cntReg + 8'h1;
        end
    end
endmodule : dsg_gearbox_model

// ---- sim/dual_spindle_gear_sequencer_bench.sv ----
/* bench for the sequencer: spindle commands, halts, alarms and range shifts.
   assumes the gearbox model and the bound checker are compiled with it. */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin badCount++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge clk); n++; end \
    if (n >= 3000) complete_run(1); end
module dual_spindle_gear_sequencer_bench;
    logic clk = 0, reset_n = 0, stall = 0, eStop = 0, spAlarm = 0;
    logic [10:0] cmd = '0;
    logic [15:0] speedValue = '0;
    logic [3:0] inPos, rangeSel;
    logic awV = 0, wV = 0, bRdy = 0, arV = 0, rRdy = 0, awR, wR, bV, arR, rV;
    logic [7:0] awA = '0, arA = '0;
    logic [31:0] wD = '0, rD, rdData, seed = 32'hd8b7;
    logic [11:0] analog, shiftSpeed, held;
    logic cwOut, ccwOut, cw2Out, ccw2Out, stopOut, serCw, lampCw, lampStop, brk;
    int badCount = 0, totalChecks = 0, n;
    dsg_sequencer u_dut (.clk(clk), .reset_n(reset_n), .s_axi_awvalid(awV),
        .s_axi_awready(awR), .s_axi_awaddr(awA), .s_axi_wvalid(wV), .s_axi_wready(wR),
        .s_axi_wdata(wD), .s_axi_wstrb(4'hf), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
        .s_axi_bresp(), .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_araddr(arA),
        .s_axi_rvalid(rV), .s_axi_rready(rRdy), .s_axi_rdata(rD), .s_axi_rresp(),
        .firstCwCmd(cmd[0]), .firstCcwCmd(cmd[1]), .firstStopCmd(cmd[2]),
        .secondCwCmd(cmd[3]), .secondCcwCmd(cmd[4]), .secondStopCmd(cmd[5]),
        .range1Cmd(cmd[6]), .range2Cmd(cmd[7]), .range3Cmd(cmd[8]), .range4Cmd(cmd[9]),
        .speedCmd(cmd[10]), .speedValue(speedValue), .emergencyStop(eStop),
        .spindleAlarm(spAlarm), .range1InPosition(inPos[0]), .range2InPosition(inPos[1]),
        .range3InPosition(inPos[2]), .range4InPosition(inPos[3]), .firstCwOut(cwOut),
        .firstCcwOut(ccwOut), .secondCwOut(cw2Out), .secondCcwOut(ccw2Out), .brakeOut(brk),
        .spindleStopOut(stopOut), .serialCwFlag(serCw), .serialCcwFlag(), .lampCw(lampCw),
        .lampCcw(), .lampStop(lampStop), .rangeSelect(rangeSel), .firstAnalog(analog),
        .secondAnalog());
    dsg_gearbox_model u_gear (.clk(clk), .reset_n(reset_n), .rangeSelect(rangeSel),
        .stall(stall), .inPosition(inPos));
    // 125 MHz control clock
    initial begin
        forever #4 clk = ~clk;
    end
    // next value of the repeatable random stream
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    // expected speed level, saturated
    function automatic logic [11:0] scaled(input int s, input int m);
        return (m == 0) ? 12'h0 : (s * 4095 / m > 4095) ? 12'hfff : 12'(s * 4095 / m);
    endfunction : scaled
    task automatic complete_run(input bit hang);
        if (hang) badCount++;
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    // bus write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        {awV, wV, bRdy} <= 3'b111;
        awA <= a;
        wD <= d;
        do begin
            @(posedge clk);
            if (awV && awR) awV <= 0;
            if (wV && wR) wV <= 0;
            k++;
        end while (!bV && k < 200);
        bRdy <= 0;
        if (k >= 200) complete_run(1);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int k = 0;
        @(posedge clk);
        {arV, rRdy} <= 2'b11;
        arA <= a;
        do begin
            @(posedge clk);
            if (arV && arR) arV <= 0;
            k++;
        end while (!rV && k < 200);
        rdData = rD;
        rRdy <= 0;
        if (k >= 200) complete_run(1);
    endtask : rd
    // one-cycle command pulse, then let the outputs settle
    task automatic pulse(input int i);
        @(posedge clk);
        cmd[i] <= 1;
        @(posedge clk);
        cmd <= '0;
        repeat (3) @(posedge clk);
    endtask : pulse
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1;
        `CHK("rangeSelect", 4'h0, rangeSel)
        rd(8'h18);
        `CHK("post delay", 32'h1388, rdData)
        rd(8'h40);
        `CHK("unmapped", 32'h0, rdData)
        pulse(0);
        `CHK("firstCw", 1'b1, cwOut)
        pulse(3);
        `CHK("second gated", 1'b0, cw2Out)
        wr(8'h00, 32'h101);
        pulse(3);
        `CHK("secondCw", 1'b1, cw2Out)
        pulse(2);
        `CHK("first stopped", 1'b0, cwOut)
        `CHK("second runs", 1'b1, cw2Out)
        `CHK("lamps", 2'b01, {lampCw, lampStop})
        pulse(4);
        `CHK("no reverse", 2'b10, {cw2Out, ccw2Out})
        pulse(5);
        `CHK("second stop", 1'b0, cw2Out)
        `CHK("brake", 1'b1, brk)
        for (int i = 0; i < 2; i++) begin
            pulse(0);
            pulse(3);
            {spAlarm, eStop} <= 2'(1 << i);
            repeat (3) @(posedge clk);
            `CHK("halt", 3'b001, {cwOut, cw2Out, stopOut})
            {spAlarm, eStop} <= 2'b00;
        end
        wr(8'h00, 32'h201);
        pulse(0);
        `CHK("serial", 2'b10, {serCw, cwOut})
        pulse(2);
        wr(8'h00, 32'h101);
        pulse(9);
        rd(8'h08);
        `CHK("alarms", 2'b11, {rdData[3], rdData[0]})
        wr(8'h08, 32'hf);
        rd(8'h08);
        `CHK("alarm clear", 32'h0, rdData)
        seed = xs(seed);
        shiftSpeed = seed[11:0];
        speedValue <= seed[31:16];
        pulse(10);
        wr(8'h0c, {20'h0, shiftSpeed});
        wr(8'h14, 32'h0);
        wr(8'h18, 32'h0);
        wr(8'h1c, 32'h1);
        wr(8'h20, xs(seed));
        wr(8'h00, 32'h183);
        pulse(7);
        `CHK("shift speed", shiftSpeed, analog)
        `WAITC(rangeSel === 4'h2)
        `WAITC(analog !== shiftSpeed)
        `CHK("scaled", scaled(seed[31:16], xs(seed) >> 16), analog)
        `CHK("held range", 4'h2, rangeSel)
        held = analog;
        pulse(7);
        `CHK("same range", held, analog)
        wr(8'h00, 32'h181);
        pulse(6);
        `WAITC(rangeSel === 4'h1)
        `WAITC(rangeSel === 4'h0)
        wr(8'h1c, 32'h0);
        stall <= 1;
        pulse(8);
        n = 0;
        do begin
            rd(8'h08);
            n++;
        end while (rdData[2] !== 1'b1 && n < 100);
        `CHK("shift timeout", 1'b1, rdData[2])
        complete_run(0);
    end
endmodule : dual_spindle_gear_sequencer_bench
